//--- shared/cmp_dac_pkg.sv
package cmp_dac_pkg;
  // register word indices (printed offsets are not all multiples of four)
  localparam logic [8:0] IDX_IRQ_ENABLE = 9'h00d;
  localparam logic [8:0] IDX_IRQ_FLAG = 9'h00e;
  localparam logic [8:0] IDX_REF_SELECT = 9'h019;
  localparam logic [8:0] IDX_CMP_CONTROL = 9'h18d;
  localparam logic [8:0] IDX_INPUT_SELECT = 9'h18e;
  localparam logic [8:0] IDX_DAC_CONTROL = 9'h18f;
  localparam int ADDR_W = 11;
  // reset values
  localparam logic [7:0] RST_CMP_CONTROL = 8'hc0;
  localparam logic [7:0] RST_INPUT_SELECT = 8'hf7;
  localparam logic [7:0] RST_DAC_CONTROL = 8'h00;
  localparam logic [7:0] RST_REF_SELECT = 8'h1f;
  // field positions
  localparam int BIT_PD = 7;
  localparam int BIT_RAW = 6;
  localparam int BIT_PIN_EN = 5;
  localparam int BIT_INV = 4;
  localparam int BIT_CMP_IRQ = 4;
  localparam int BIT_NEG_SRC = 7;
  localparam int BIT_DAC_REF = 7;
  // writable masks
  localparam logic [7:0] MASK_CMP_CONTROL = 8'hbf;
  localparam logic [7:0] MASK_INPUT_SELECT = 8'hff;
  localparam logic [7:0] MASK_REF_SELECT = 8'hdf;
  localparam logic [7:0] MASK_IRQ = 8'h10;
  // de-bounce lengths in system clock periods
  localparam logic [4:0] DB_LEN_1 = 5'h04;
  localparam logic [4:0] DB_LEN_2 = 5'h08;
  localparam logic [4:0] DB_LEN_3 = 5'h10;
  // pin selects
  localparam logic [2:0] SEL_PIN_A = 3'h0;
  localparam logic [2:0] SEL_PIN_B = 3'h1;
  localparam logic [2:0] SEL_PIN_C = 3'h2;
  localparam logic [2:0] SEL_PIN_D = 3'h3;

  typedef enum logic [1:0] {
    TRIG_RISE,
    TRIG_FALL,
    TRIG_BOTH,
    TRIG_HIGH
  } trig_e;

  // analog control bundle sent to the comparator core and ladder
  typedef struct packed {
    logic power_down;
    logic dac_ref_select;
    logic [6:0] dac_level_code;
    logic [1:0] bandgap_level_select;
    logic neg_from_dac;
    logic [3:0] neg_pin_onehot;
    logic [2:0] pos_pin_onehot;
  } analog_ctl_s;

  typedef struct packed {
    logic [7:0] irq_enable;
    logic [7:0] irq_flag;
    logic [7:0] ref_select;
    logic [7:0] cmp_control;
    logic [7:0] input_select;
    logic [7:0] dac_control;
    logic raw_sync;
    logic raw_q;
    logic [4:0] db_count;
    logic debounced;
    logic final_q;
    logic final_valid;
    logic pin_out;
    logic pin_oe;
    logic irq;
    logic [31:0] readdata;
    logic waitrequest;
    logic ack;
    analog_ctl_s analog;
  } cmp_state_s;
endpackage

//--- src/comparator_dac_control.sv
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
// Functional notes
// - dac reference: supply when clear, bandgap set
// - dac out is code over 128 times ref
// - power-down bit gates dac and comparator, resets one
// - negative input from pin or dac output
// - negative pin select decode, 010 reserved, 1xx open
// - positive pin select decode, 011 reserved, 1xx open
// - raw result readable, one when powered down
// - de-bounce none, 4, 8, 16 clocks
// - optional inversion forms final output
// - pin enable drives final output to pin
// - trigger: rise, fall, both, high level
// - hardware sets pending flag on trigger
// - writing zero bit clears pending flag
// - flags still produced while powered down
// - irq only when enabled and pending
// - bandgap level field, code 11 unfit
module comparator_dac_control (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [cmp_dac_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic cmp_raw_i,
  output cmp_dac_pkg::analog_ctl_s analog_ctl_o,
  output logic final_compare_out_o,
  output logic compare_pin_o,
  output logic compare_pin_oe_o,
  output logic irq_o
);
  import cmp_dac_pkg::*;

  cmp_state_s st;
  cmp_state_s next_st;

  logic [8:0] idx;
  logic access;
  logic wr_lane0;
  logic [7:0] wbyte;
  logic raw_eff;
  logic [4:0] db_len;
  logic trig_hit;
  logic [7:0] rd_byte;

  // byte-address to word index; low two bits ignored
  assign idx = avs_address_i[ADDR_W-1:2];
  assign access = (avs_read_i | avs_write_i) & ~st.ack;
  // a write lands at the completing edge, where the master sees waitrequest low
  assign wr_lane0 = avs_write_i & st.ack & avs_byteenable_i[0];
  assign wbyte = avs_writedata_i[7:0];

  // power-down forces the raw result high; the flag logic keeps running on it
  assign raw_eff = st.raw_q | st.cmp_control[BIT_PD];

  // de-bounce length table
  always_comb begin
    case (st.cmp_control[1:0])
      2'b01: db_len = DB_LEN_1;
      2'b10: db_len = DB_LEN_2;
      2'b11: db_len = DB_LEN_3;
      default: db_len = '0;
    endcase
  end

  // register read mux; unmapped indices read zero
  always_comb begin
    case (idx)
      IDX_IRQ_ENABLE: rd_byte = st.irq_enable;
      IDX_IRQ_FLAG: rd_byte = st.irq_flag;
      IDX_REF_SELECT: rd_byte = st.ref_select;
      IDX_CMP_CONTROL: begin
        rd_byte = st.cmp_control;
        rd_byte[BIT_RAW] = raw_eff;
      end
      IDX_INPUT_SELECT: rd_byte = st.input_select;
      IDX_DAC_CONTROL: rd_byte = st.dac_control;
      default: rd_byte = '0;
    endcase
  end

  // trigger condition on the final output; edges judged against its previous value, high level on the new value alone
  always_comb begin
    case (trig_e'(st.cmp_control[3:2]))
      TRIG_RISE: trig_hit = st.final_valid & next_st.final_q & ~st.final_q;
      TRIG_FALL: trig_hit = st.final_valid & ~next_st.final_q & st.final_q;
      TRIG_BOTH: trig_hit = st.final_valid & (next_st.final_q ^ st.final_q);
      TRIG_HIGH: trig_hit = next_st.final_q;
      default: trig_hit = 1'b0;
    endcase
  end

  // next-state computation for everything the block holds
  always_comb begin
    next_st = st;
    next_st.raw_sync = cmp_raw_i;
    next_st.raw_q = st.raw_sync;
    // de-bounce: count consecutive cycles the raw level differs from output
    if (db_len == '0) begin
      next_st.debounced = raw_eff;
      next_st.db_count = '0;
    end else if (raw_eff == st.debounced) begin
      next_st.db_count = '0;
    end else if (st.db_count + 5'h01 >= db_len) begin
      next_st.debounced = raw_eff;
      next_st.db_count = '0;
    end else begin
      next_st.db_count = st.db_count + 5'h01;
    end
    next_st.final_q = next_st.debounced ^ st.cmp_control[BIT_INV];
    next_st.final_valid = 1'b1;
    // pad drive; the pin mode field elsewhere must also select this function
    next_st.pin_out = next_st.final_q;
    next_st.pin_oe = st.cmp_control[BIT_PIN_EN];
    // bus: one wait cycle, then answer with ack
    next_st.ack = access;
    next_st.waitrequest = ~access;
    if (avs_read_i & ~st.ack) begin
      next_st.readdata = {24'h000000, rd_byte};
    end
    if (wr_lane0) begin
      case (idx)
        IDX_IRQ_ENABLE: next_st.irq_enable = wbyte & MASK_IRQ;
        IDX_REF_SELECT: next_st.ref_select = wbyte & MASK_REF_SELECT;
        IDX_CMP_CONTROL: next_st.cmp_control = wbyte & MASK_CMP_CONTROL;
        IDX_INPUT_SELECT: next_st.input_select = wbyte & MASK_INPUT_SELECT;
        IDX_DAC_CONTROL: next_st.dac_control = wbyte;
        default: ;
      endcase
    end
    // flag: zero written in its position clears, a trigger in the same cycle wins
    if (wr_lane0 && idx == IDX_IRQ_FLAG && !wbyte[BIT_CMP_IRQ]) begin
      next_st.irq_flag[BIT_CMP_IRQ] = 1'b0;
    end
    if (trig_hit) begin
      next_st.irq_flag[BIT_CMP_IRQ] = 1'b1;
    end
    next_st.irq = |(next_st.irq_flag & next_st.irq_enable);
    // analog steering
    next_st.analog.power_down = next_st.cmp_control[BIT_PD];
    next_st.analog.dac_ref_select = next_st.dac_control[BIT_DAC_REF];
    next_st.analog.dac_level_code = next_st.dac_control[6:0];
    next_st.analog.bandgap_level_select = next_st.ref_select[7:6];
    next_st.analog.neg_from_dac = next_st.input_select[BIT_NEG_SRC];
    next_st.analog.neg_pin_onehot = '0;
    case (next_st.input_select[6:4])
      SEL_PIN_A: next_st.analog.neg_pin_onehot = 4'b0001;
      SEL_PIN_B: next_st.analog.neg_pin_onehot = 4'b0010;
      SEL_PIN_D: next_st.analog.neg_pin_onehot = 4'b1000;
      default: ; // reserved and 1xx leave the input open
    endcase
    if (next_st.input_select[BIT_NEG_SRC]) begin
      next_st.analog.neg_pin_onehot = '0;
    end
    next_st.analog.pos_pin_onehot = '0;
    case (next_st.input_select[2:0])
      SEL_PIN_A: next_st.analog.pos_pin_onehot = 3'b001;
      SEL_PIN_B: next_st.analog.pos_pin_onehot = 3'b010;
      SEL_PIN_C: next_st.analog.pos_pin_onehot = 3'b100;
      default: ;
    endcase
    if (srst_i) begin
      next_st = '0;
      next_st.cmp_control = RST_CMP_CONTROL & MASK_CMP_CONTROL;
      next_st.input_select = RST_INPUT_SELECT;
      next_st.dac_control = RST_DAC_CONTROL;
      next_st.ref_select = RST_REF_SELECT;
      next_st.waitrequest = 1'b1;
      next_st.debounced = 1'b1;
      next_st.final_q = 1'b1;
      next_st.analog.power_down = 1'b1;
      next_st.analog.neg_from_dac = 1'b1;
    end
  end

  // single state register; reset handled synchronously in the copy above
  always_ff @(posedge mclk_i) begin
    st <= next_st;
  end

  // all outputs straight from flops
  assign avs_readdata_o = st.readdata;
  assign avs_waitrequest_o = st.waitrequest;
  assign analog_ctl_o = st.analog;
  assign final_compare_out_o = st.final_q;
  assign compare_pin_o = st.pin_out;
  assign compare_pin_oe_o = st.pin_oe;
  assign irq_o = st.irq;
endmodule

//--- test/comparator_dac_control_sva.sv
`timescale 1ns/100ps
module comparator_dac_control_sva import cmp_dac_pkg::*; (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [cmp_dac_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic cmp_raw_i,
  input cmp_dac_pkg::analog_ctl_s analog_ctl_o,
  input wire logic final_compare_out_o,
  input wire logic compare_pin_o,
  input wire logic compare_pin_oe_o,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // a pending request, and the pin held enabled over a steady output
  sequence req_s;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence pin_steady_s;
    (compare_pin_oe_o && $stable(final_compare_out_o)) [*2];
  endsequence
  wait_answer_a: assert property (req_s |-> ##[1:2] !avs_waitrequest_o)
    else $error("request not answered");
  wait_once_a: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  answer_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without request");
  rdata_upper_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  reset_state_a: assert property ($fell(srst_i) |-> analog_ctl_o.power_down && !irq_o &&
    !compare_pin_oe_o && final_compare_out_o) else $error("bad state after reset");
  neg_decode_a: assert property ($onehot0(analog_ctl_o.neg_pin_onehot))
    else $error("negative select not one-hot");
  pos_decode_a: assert property ($onehot0(analog_ctl_o.pos_pin_onehot))
    else $error("positive select not one-hot");
  pin_follow_a: assert property (pin_steady_s |-> compare_pin_o == final_compare_out_o)
    else $error("pin differs from output");
endmodule
bind comparator_dac_control comparator_dac_control_sva sva (.*);

//--- test/cmp_core_model.sv
`timescale 1ns/100ps
module cmp_core_model import cmp_dac_pkg::*; (
  input wire logic mclk_i,
  input cmp_dac_pkg::analog_ctl_s analog_ctl_i,
  input wire logic pos_gt_i,
  output logic cmp_raw_o
);
  logic routed;
  // an open input side gives no decision, read here as low
  assign routed = (|analog_ctl_i.pos_pin_onehot) &&
    (analog_ctl_i.neg_from_dac || (|analog_ctl_i.neg_pin_onehot));
  // a powered-down core parks its output high
  always_ff @(posedge mclk_i) begin
    cmp_raw_o <= analog_ctl_i.power_down | (routed & pos_gt_i);
  end
endmodule

//--- test/test_comparator_dac_control.sv
`timescale 1ns/100ps
module test_comparator_dac_control;
  import cmp_dac_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic [31:0] avs_readdata_o, rd;
  logic avs_waitrequest_o, cmp_raw_i, final_compare_out_o;
  logic compare_pin_o, compare_pin_oe_o, irq_o;
  logic pos_gt = 1'b0;
  analog_ctl_s analog_ctl_o;
  int miscompares = 0;
  int comparisons = 0;
  always #2.5 mclk_i = ~mclk_i;
  comparator_dac_control dut (.*);
  cmp_core_model core (.mclk_i(mclk_i), .analog_ctl_i(analog_ctl_o), .pos_gt_i(pos_gt),
    .cmp_raw_o(cmp_raw_i));
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one bus access; request held until waitrequest is sampled low
  task automatic acc(logic we, logic [8:0] idx, logic [7:0] wd);
    int n;
    @(posedge mclk_i);
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h0, wd};
    avs_write_i <= we;
    avs_read_i <= !we;
    for (n = 0; n < 20; n++) begin
      @(posedge mclk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n == 20) begin
      miscompares++;
      give_verdict();
    end
  endtask
  task automatic rdchk(string what, logic [8:0] idx, logic [31:0] exp);
    acc(1'b0, idx, 8'h00);
    chk(what, rd, exp);
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge mclk_i);
  endtask
  initial begin
    int i;
    logic [31:0] negt;
    logic [31:0] post;
    negt = 32'h8021;
    post = 32'h0421;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    rdchk("ctl", IDX_CMP_CONTROL, 32'hc0);
    rdchk("dac", IDX_DAC_CONTROL, 32'h0);
    acc(1'b1, IDX_DAC_CONTROL, 8'hd5);
    acc(1'b1, IDX_REF_SELECT, 8'h5f);
    wt(2);
    chk("lvl", {analog_ctl_o.dac_ref_select, analog_ctl_o.dac_level_code}, 32'hd5);
    chk("bg", analog_ctl_o.bandgap_level_select, 32'h1);
    // every select code of both pin fields
    for (i = 0; i < 8; i++) begin
      acc(1'b1, IDX_INPUT_SELECT, {1'b0, i[2:0], 1'b1, i[2:0]});
      wt(2);
      chk("neg", analog_ctl_o.neg_pin_onehot, negt[i*4 +: 4]);
      chk("pos", analog_ctl_o.pos_pin_onehot, post[i*4 +: 4]);
    end
    acc(1'b1, IDX_INPUT_SELECT, 8'h88);
    wt(2);
    chk("src", analog_ctl_o.neg_from_dac, 32'h1);
    acc(1'b1, IDX_CMP_CONTROL, 8'h01);
    wt(12);
    acc(1'b1, IDX_IRQ_FLAG, 8'hef);
    acc(1'b1, IDX_IRQ_ENABLE, 8'h10);
    pos_gt <= 1'b1;
    wt(3);
    pos_gt <= 1'b0;
    wt(12);
    rdchk("glitch", IDX_IRQ_FLAG, 32'h0);
    pos_gt <= 1'b1;
    wt(12);
    chk("fin", final_compare_out_o, 32'h1);
    chk("irq", irq_o, 32'h1);
    rdchk("raw", IDX_CMP_CONTROL, 32'h41);
    acc(1'b1, IDX_IRQ_ENABLE, 8'h00);
    wt(2);
    chk("mask", irq_o, 32'h0);
    pos_gt <= 1'b0;
    wt(12);
    // rising output under each trigger mode, pin enabled
    for (i = 0; i < 4; i++) begin
      acc(1'b1, IDX_CMP_CONTROL, {4'h2, i[1:0], 2'b01});
      acc(1'b1, IDX_IRQ_FLAG, 8'hef);
      pos_gt <= 1'b1;
      wt(12);
      rdchk("trig", IDX_IRQ_FLAG, (i == 1) ? 32'h0 : 32'h10);
      chk("pin", {compare_pin_oe_o, compare_pin_o}, 32'h3);
      pos_gt <= 1'b0;
      wt(12);
    end
    acc(1'b1, IDX_CMP_CONTROL, 8'h11);
    wt(12);
    chk("inv", final_compare_out_o, 32'h1);
    acc(1'b1, IDX_CMP_CONTROL, 8'h00);
    wt(4);
    acc(1'b1, IDX_IRQ_FLAG, 8'hef);
    rdchk("clr", IDX_IRQ_FLAG, 32'h0);
    acc(1'b1, IDX_CMP_CONTROL, 8'h80);
    wt(8);
    rdchk("pdflag", IDX_IRQ_FLAG, 32'h10);
    rdchk("pdraw", IDX_CMP_CONTROL, 32'hc0);
    rdchk("hole", 9'h100, 32'h0);
    give_verdict();
  end
endmodule
